// File: rtl/uml_pkg.sv
// uml_pkg: constants and carriers for the modem-control, line-status
// and modem-status block of the serial port.
// assumes an 8-bit host i/o port and a same-clock transmitter/receiver.
package uml_pkg;

  ////////////////////////////////////////////////////////////////////////
  // host i/o addresses
  localparam logic [15:0] UML_ADDR_MCR = 16'h03fc;
  localparam logic [15:0] UML_ADDR_LSR = 16'h03fd;
  localparam logic [15:0] UML_ADDR_MSR = 16'h03fe;

  ////////////////////////////////////////////////////////////////////////
  // modem_line_control fields
  localparam int UML_MCR_DTR  = 0;
  localparam int UML_MCR_RTS  = 1;
  localparam int UML_MCR_SPARE_USER_OUTPUT = 2;
  localparam int UML_MCR_IRQ_GATE_OUTPUT = 3;
  localparam int UML_MCR_LOOP = 4;
  localparam logic [4:0] UML_MCR_RESET = 5'h00;

  // line_condition_status fields
  localparam int UML_LSR_DR   = 0;
  localparam int UML_LSR_OE   = 1;
  localparam int UML_LSR_PE   = 2;
  localparam int UML_LSR_FE   = 3;
  localparam int UML_LSR_BI   = 4;
  localparam int UML_LSR_THRE = 5;
  localparam int UML_LSR_TEMT = 6;
  localparam logic [6:0] UML_LSR_RESET = 7'h60;

  // modem_input_status fields: deltas 3-0, levels 7-4
  localparam int UML_MSR_DCTS = 0;
  localparam int UML_MSR_DDSR = 1;
  localparam int UML_MSR_TERI = 2;
  localparam int UML_MSR_DCD  = 3;
  localparam logic [3:0] UML_MSR_RESET = 4'h0;

  // edges after reset before modem line changes are trusted
  localparam logic [1:0] UML_SETTLE_LAST = 2'h3;

  // bit width of the character time in clock cycles (the default is a parameter of the top)
  localparam int UML_CHAR_CYCLES_W = 20;

  ////////////////////////////////////////////////////////////////////////
  // modem input lines: order matches status bits 7-4
  typedef struct packed {
    logic rlsd;
    logic ri;
    logic dsr;
    logic cts;
  } uml_modem_t;

  // receiver events, one-cycle pulses
  typedef struct packed {
    logic char_done;
    logic parity_err;
    logic framing_err;
    logic rbr_read;
  } uml_rx_evt_t;

  // transmitter events, one-cycle pulses
  typedef struct packed {
    logic thr_write;
    logic holding_free;
    logic shifter_idle;
  } uml_tx_evt_t;

  // interrupt conditions handed to the identification logic
  typedef struct packed {
    logic line_status;
    logic rx_avail;
    logic thr_empty;
    logic modem_status;
  } uml_irq_cond_t;

endpackage : uml_pkg

// File: rtl/uml_line_watch.sv
// uml_line_watch: pin synchronisers and line break timer.
// assumes raw pins are asynchronous; tx data is on i_clk.
`timescale 1ns/1ps
`default_nettype none
module uml_line_watch #(
  parameter int SYNC_W = 5
) (
  // clock and reset
  input  wire logic                                  i_clk,
  input  wire logic                                  i_sys_rst,
  // raw pins
  input  wire logic [SYNC_W-1:0]                     i_pins_async,
  // line selection
  input  wire logic                                  i_loop,
  input  wire logic                                  i_tx_ser,
  input  wire logic [uml_pkg::UML_CHAR_CYCLES_W-1:0] i_char_cycles,
  // results
  output logic      [SYNC_W-1:0]                     o_pins_sync,
  output logic                                       o_rx_eff,
  output logic                                       o_break_evt
);
  import uml_pkg::*;

  logic [SYNC_W-1:0]            meta;
  logic [SYNC_W-1:0]            sync;
  logic [UML_CHAR_CYCLES_W-1:0] mark_cnt;
  logic [UML_CHAR_CYCLES_W-1:0] next_mark_cnt;
  logic                         brk;
  logic                         next_brk;

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser per pin
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_sync
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          meta[g] <= 1'b1;
          sync[g] <= 1'b1;
        end else begin
          meta[g] <= i_pins_async[g];
          sync[g] <= meta[g];
        end
      end
    end
  endgenerate

  assign o_pins_sync = sync;

  ////////////////////////////////////////////////////////////////////////
  // receive input: external pin is ignored in loopback
  assign o_rx_eff = i_loop ? i_tx_ser : sync[0];

  // mark held over one character time flags a break, once per hold
  always_comb begin
    next_mark_cnt = mark_cnt;
    next_brk      = 1'b0;
    if (!o_rx_eff) begin
      next_mark_cnt = '0;
    end else if (mark_cnt <= i_char_cycles) begin
      next_mark_cnt = mark_cnt + 1'b1;
      // counter stops past the limit so one long hold gives one pulse
      next_brk      = (mark_cnt == i_char_cycles) && (i_char_cycles != '0);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mark_cnt <= '0;
      brk      <= 1'b0;
    end else begin
      mark_cnt <= next_mark_cnt;
      brk      <= next_brk;
    end
  end

  assign o_break_evt = brk;

endmodule : uml_line_watch
`default_nettype wire

// File: rtl/uml_modem_line.sv
// uml_modem_line: modem control, line status, modem status and loopback.
// assumes host i/o strobes, transmitter and receiver all run on i_clk.
//
// Operation
// - mcr bit 4 turns loopback on/off
// - mcr bit 3 gates port interrupt out
// - mcr bit 2 stored, readable, drives ri in loopback
// - rts and dtr bits drive connector levels
// - loopback holds serial output at zero
// - loopback feeds tx output to receiver
// - loopback routes modem outputs to inputs
// - rx and thr interrupts unchanged in loopback
// - loopback writes set line status 5-0
// - loopback writes set modem status 3-0
// - lsr bit 6 shows shifter idle
// - lsr bit 5 shows holding register free
// - long mark sets break bit
// - missing stop bit sets framing bit
// - bad parity sets parity bit
// - char before buffer read sets overrun
// - assembled char sets data ready
// - lsr bits 4-0 clear on read or on a written zero
// - bits 4-1 line irq, bit 0 rx irq
// - msr 7-4 show rlsd ri dsr cts
// - rlsd change sets bit 3, read clears
// - ri rising edge sets bit 2
// - dsr/cts changes set bits 1/0
// - any msr bit 3-0 means modem irq
`timescale 1ns/1ps
`default_nettype none
module uml_modem_line #(
  parameter logic [uml_pkg::UML_CHAR_CYCLES_W-1:0] CHAR_CYCLES_DEF = 20'h0_0000
) (
  // clock and reset
  input  wire logic                                  i_clk,
  input  wire logic                                  i_sys_rst,
  // host i/o port
  input  wire logic [15:0]                           i_io_addr,
  input  wire logic                                  i_io_wr,
  input  wire logic                                  i_io_rd,
  input  wire logic [7:0]                            i_io_wdata,
  output logic      [7:0]                            o_io_rdata,
  // transmitter and receiver neighbours
  input  wire logic                                  i_tx_ser,
  input  wire uml_pkg::uml_tx_evt_t                  i_tx_evt,
  input  wire uml_pkg::uml_rx_evt_t                  i_rx_evt,
  input  wire logic [uml_pkg::UML_CHAR_CYCLES_W-1:0] i_char_cycles,
  output logic                                       o_rx_ser,
  // interrupt path
  input  wire logic                                  i_port_irq,
  output uml_pkg::uml_irq_cond_t                     o_irq_cond,
  output logic                                       o_irq,
  // connector lines
  input  wire logic                                  i_rx_pin,
  input  wire uml_pkg::uml_modem_t                   i_modem_pins,
  output logic                                       o_ser_out,
  output logic                                       o_rts,
  output logic                                       o_dtr
);
  import uml_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [4:0]                   mcr;
  logic [4:0]                   next_mcr;
  logic [6:0]                   lsr;
  logic [6:0]                   next_lsr;
  logic [3:0]                   msr_delta;
  logic [3:0]                   next_msr_delta;
  logic [1:0]                   settle;
  logic [1:0]                   next_settle;
  uml_modem_t                   modem_prev;
  uml_modem_t                   modem_eff;
  uml_modem_t                   modem_sync;
  logic [4:0]                   pins_sync;
  logic                         rx_eff;
  logic                         break_evt;
  logic [UML_CHAR_CYCLES_W-1:0] char_cycles;
  logic                         loop_on;
  logic                         wr_mcr;
  logic                         wr_lsr;
  logic                         wr_msr;
  logic                         rd_mcr;
  logic                         rd_lsr;
  logic                         rd_msr;
  logic [7:0]                   next_rdata;
  uml_irq_cond_t                next_irq_cond;
  logic                         next_irq;
  logic                         next_ser_out;
  logic                         next_rx_ser;

  ////////////////////////////////////////////////////////////////////////
  // address decode
  assign wr_mcr  = i_io_wr && (i_io_addr == UML_ADDR_MCR);
  assign wr_lsr  = i_io_wr && (i_io_addr == UML_ADDR_LSR);
  assign wr_msr  = i_io_wr && (i_io_addr == UML_ADDR_MSR);
  assign rd_mcr  = i_io_rd && (i_io_addr == UML_ADDR_MCR);
  assign rd_lsr  = i_io_rd && (i_io_addr == UML_ADDR_LSR);
  assign rd_msr  = i_io_rd && (i_io_addr == UML_ADDR_MSR);
  assign loop_on = mcr[UML_MCR_LOOP];

  // a zero character time from the baud logic falls back to the default
  assign char_cycles = (i_char_cycles != '0) ? i_char_cycles : CHAR_CYCLES_DEF;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and break timer
  uml_line_watch #(
    .SYNC_W (5)
  ) u_line_watch (
    .i_clk         (i_clk),
    .i_sys_rst     (i_sys_rst),
    .i_pins_async  ({i_modem_pins, i_rx_pin}),
    .i_loop        (loop_on),
    .i_tx_ser      (i_tx_ser),
    .i_char_cycles (char_cycles),
    .o_pins_sync   (pins_sync),
    .o_rx_eff      (rx_eff),
    .o_break_evt   (break_evt)
  );

  assign modem_sync = uml_modem_t'(pins_sync[4:1]);

  ////////////////////////////////////////////////////////////////////////
  // effective modem inputs: external lines cut off in loopback
  always_comb begin
    if (loop_on) begin
      modem_eff.dsr  = mcr[UML_MCR_DTR];
      modem_eff.cts  = mcr[UML_MCR_RTS];
      modem_eff.ri   = mcr[UML_MCR_SPARE_USER_OUTPUT];
      modem_eff.rlsd = mcr[UML_MCR_IRQ_GATE_OUTPUT];
    end else begin
      modem_eff = modem_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // modem_line_control
  always_comb begin
    next_mcr = mcr;
    if (wr_mcr) begin
      // bit 2 is read back and drives ri in loopback
      next_mcr = i_io_wdata[4:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mcr <= UML_MCR_RESET;
    end else begin
      mcr <= next_mcr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line_condition_status
  always_comb begin
    next_lsr = lsr;
    // software side first, so hardware sets below win over clears
    if (rd_lsr) begin
      next_lsr[4:0] = 5'h00;
    end
    if (wr_lsr) begin
      if (loop_on) begin
        next_lsr[5:0] = i_io_wdata[5:0];
      end else begin
        // a written zero clears, a written one leaves the bit alone
        next_lsr[4:0] = lsr[4:0] & i_io_wdata[4:0];
      end
    end
    if (i_rx_evt.rbr_read) begin
      next_lsr[UML_LSR_DR] = 1'b0;
    end
    if (i_tx_evt.thr_write) begin
      next_lsr[UML_LSR_THRE] = 1'b0;
      next_lsr[UML_LSR_TEMT] = 1'b0;
    end
    if (i_tx_evt.holding_free) begin
      next_lsr[UML_LSR_THRE] = 1'b1;
    end
    if (i_tx_evt.shifter_idle) begin
      next_lsr[UML_LSR_TEMT] = 1'b1;
    end
    if (break_evt) begin
      next_lsr[UML_LSR_BI] = 1'b1;
    end
    if (i_rx_evt.char_done) begin
      // old data still unread and not being read now is lost
      if (lsr[UML_LSR_DR] && !i_rx_evt.rbr_read) begin
        next_lsr[UML_LSR_OE] = 1'b1;
      end
      next_lsr[UML_LSR_DR] = 1'b1;
      if (i_rx_evt.framing_err) begin
        next_lsr[UML_LSR_FE] = 1'b1;
      end
      if (i_rx_evt.parity_err) begin
        next_lsr[UML_LSR_PE] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      lsr <= UML_LSR_RESET;
    end else begin
      lsr <= next_lsr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // modem_input_status deltas
  always_comb begin
    next_msr_delta = msr_delta;
    next_settle    = settle;
    if (settle != UML_SETTLE_LAST) begin
      next_settle = settle + 2'h1;
    end
    if (rd_msr) begin
      next_msr_delta = 4'h0;
    end
    if (wr_msr && loop_on) begin
      next_msr_delta = next_msr_delta | i_io_wdata[3:0];
    end
    // synchronisers and modem_prev still hold reset values for a few
    // edges; comparing them then reports changes that never happened
    if (settle == UML_SETTLE_LAST) begin
      // change detection last so an event in the read cycle is kept
      if (modem_eff.rlsd != modem_prev.rlsd) begin
        next_msr_delta[UML_MSR_DCD] = 1'b1;
      end
      if (modem_eff.ri && !modem_prev.ri) begin
        next_msr_delta[UML_MSR_TERI] = 1'b1;
      end
      if (modem_eff.dsr != modem_prev.dsr) begin
        next_msr_delta[UML_MSR_DDSR] = 1'b1;
      end
      if (modem_eff.cts != modem_prev.cts) begin
        next_msr_delta[UML_MSR_DCTS] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      msr_delta  <= UML_MSR_RESET;
      modem_prev <= '0;
      settle     <= 2'h0;
    end else begin
      msr_delta  <= next_msr_delta;
      modem_prev <= modem_eff;
      settle     <= next_settle;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, interrupt conditions and line outputs
  always_comb begin
    next_rdata = o_io_rdata;
    if (rd_mcr) begin
      next_rdata = {3'h0, mcr};
    end else if (rd_lsr) begin
      next_rdata = {1'b0, lsr};
    end else if (rd_msr) begin
      next_rdata = {modem_eff, msr_delta};
    end else if (i_io_rd) begin
      // unmapped address in this block reads as zero
      next_rdata = 8'h00;
    end
  end

  always_comb begin
    // thr and rx conditions are the same whether looped or not
    next_irq_cond.line_status  = |lsr[UML_LSR_BI:UML_LSR_OE];
    next_irq_cond.rx_avail     = lsr[UML_LSR_DR];
    next_irq_cond.thr_empty    = lsr[UML_LSR_THRE];
    next_irq_cond.modem_status = |msr_delta;
    next_irq                   = i_port_irq && mcr[UML_MCR_IRQ_GATE_OUTPUT];
    next_ser_out               = loop_on ? 1'b0 : i_tx_ser;
    next_rx_ser                = rx_eff;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_io_rdata <= 8'h00;
      o_irq_cond <= '0;
      o_irq      <= 1'b0;
      o_ser_out  <= 1'b1;
      o_rx_ser   <= 1'b1;
      o_rts      <= 1'b0;
      o_dtr      <= 1'b0;
    end else begin
      o_io_rdata <= next_rdata;
      o_irq_cond <= next_irq_cond;
      o_irq      <= next_irq;
      o_ser_out  <= next_ser_out;
      o_rx_ser   <= next_rx_ser;
      o_rts      <= next_mcr[UML_MCR_RTS];
      o_dtr      <= next_mcr[UML_MCR_DTR];
    end
  end

endmodule : uml_modem_line
`default_nettype wire

// File: verification/uml_modem_line_checker.sv
// uml_modem_line_checker: port-level assertions for the modem line block.
// assumes single-cycle host strobes; bound to every instance of the block.
`timescale 1ns/1ps
`default_nettype none
module uml_modem_line_checker #(
  parameter logic [uml_pkg::UML_CHAR_CYCLES_W-1:0] CHAR_CYCLES_DEF = 20'h0_0000
) (
  // clock and reset
  input wire logic                   i_clk,
  input wire logic                   i_sys_rst,
  // host port
  input wire logic [15:0]            i_io_addr,
  input wire logic                   i_io_wr,
  input wire logic                   i_io_rd,
  input wire logic [7:0]             i_io_wdata,
  input wire logic [7:0]             o_io_rdata,
  // transmitter and receiver side
  input wire logic                   i_tx_ser,
  input wire uml_pkg::uml_tx_evt_t   i_tx_evt,
  input wire uml_pkg::uml_rx_evt_t   i_rx_evt,
  input wire logic [uml_pkg::UML_CHAR_CYCLES_W-1:0] i_char_cycles,
  input wire logic                   o_rx_ser,
  // interrupt path
  input wire logic                   i_port_irq,
  input wire uml_pkg::uml_irq_cond_t o_irq_cond,
  input wire logic                   o_irq,
  // connector
  input wire logic                   i_rx_pin,
  input wire uml_pkg::uml_modem_t    i_modem_pins,
  input wire logic                   o_ser_out,
  input wire logic                   o_rts,
  input wire logic                   o_dtr
);
  import uml_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // shadow of the control register, rebuilt from host writes
  logic [4:0] mcr_q;
  logic [4:0] next_mcr_q;
  always_comb begin
    next_mcr_q = mcr_q;
    if (i_io_wr && i_io_addr == UML_ADDR_MCR) begin
      next_mcr_q = i_io_wdata[4:0];
    end
  end
  always_ff @(posedge i_clk) begin
    mcr_q <= i_sys_rst ? UML_MCR_RESET : next_mcr_q;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////////////////////////////////////
  loop_ser_zero_a: assert property (
    $past(mcr_q[UML_MCR_LOOP]) && !$past(i_sys_rst) |-> !o_ser_out) else $error("ser out not low in loop");
  ser_pass_a: assert property (
    !$past(mcr_q[UML_MCR_LOOP]) && !$past(i_sys_rst) |-> o_ser_out == $past(i_tx_ser)) else $error("ser out wrong");
  modem_out_a: assert property (
    $stable(mcr_q) |-> {o_rts, o_dtr} == mcr_q[1:0]) else $error("rts dtr wrong");
  irq_gate_a: assert property (
    !$past(i_sys_rst) && $stable(mcr_q) |-> o_irq == ($past(i_port_irq) && mcr_q[UML_MCR_IRQ_GATE_OUTPUT]))
    else $error("irq gate wrong");
  rx_loop_a: assert property (
    !$past(i_sys_rst) && $stable(mcr_q) && mcr_q[UML_MCR_LOOP] |-> o_rx_ser == $past(i_tx_ser))
    else $error("loop rx wrong");
  mcr_read_a: assert property (
    $past(i_io_rd && !i_io_wr && i_io_addr == UML_ADDR_MCR) && !$past(i_sys_rst)
    |-> o_io_rdata == {3'h0, $past(mcr_q)}) else $error("mcr read wrong");
  thr_clear_a: assert property (
    i_tx_evt.thr_write && !i_tx_evt.holding_free |-> ##[1:2] !o_irq_cond.thr_empty) else $error("thr not cleared");
  thr_set_a: assert property (
    i_tx_evt.holding_free |-> ##[1:2] o_irq_cond.thr_empty) else $error("thr not set");
  rx_avail_a: assert property (
    i_rx_evt.char_done |-> ##[1:2] o_irq_cond.rx_avail) else $error("rx avail missing");
  line_err_a: assert property (
    i_rx_evt.char_done && (i_rx_evt.parity_err || i_rx_evt.framing_err) |-> ##[1:2] o_irq_cond.line_status)
    else $error("line irq missing");
  msr_loop_a: assert property (
    i_io_wr && i_io_addr == UML_ADDR_MSR && mcr_q[UML_MCR_LOOP] && |i_io_wdata[3:0]
    |-> ##[1:2] o_irq_cond.modem_status) else $error("modem irq missing");
  cover property (i_io_wr && i_io_addr == UML_ADDR_MCR && i_io_wdata[UML_MCR_LOOP]);
  cover property (i_rx_evt.char_done && i_rx_evt.parity_err);
  cover property (i_io_rd && i_io_addr == UML_ADDR_MSR && mcr_q[UML_MCR_LOOP]);
endmodule : uml_modem_line_checker
bind uml_modem_line uml_modem_line_checker #(.CHAR_CYCLES_DEF(CHAR_CYCLES_DEF)) u_checker (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
  .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata), .i_tx_ser(i_tx_ser), .i_tx_evt(i_tx_evt),
  .i_rx_evt(i_rx_evt), .i_char_cycles(i_char_cycles), .o_rx_ser(o_rx_ser), .i_port_irq(i_port_irq),
  .o_irq_cond(o_irq_cond), .o_irq(o_irq), .i_rx_pin(i_rx_pin), .i_modem_pins(i_modem_pins),
  .o_ser_out(o_ser_out), .o_rts(o_rts), .o_dtr(o_dtr));
`default_nettype wire

// File: verification/uml_data_set.sv
// uml_data_set: behavioural far-end modem for the serial port bench.
// assumes the bench sets carrier, ring and the receive line level.
`timescale 1ns/1ps
`default_nettype none
module uml_data_set #(
  parameter int LAG = 3
) (
  // clock
  input  wire logic          i_clk,
  // terminal handshake outputs
  input  wire logic          i_rts,
  input  wire logic          i_dtr,
  // bench controls
  input  wire logic          i_carrier,
  input  wire logic          i_ring,
  input  wire logic          i_line,
  // lines toward the terminal
  output uml_pkg::uml_modem_t o_pins,
  output logic               o_rx
);
  import uml_pkg::*;
  logic [LAG-1:0] rts_dly;
  logic [LAG-1:0] dtr_dly;
  // a slow modem: handshakes answered some cycles late
  always_ff @(posedge i_clk) begin
    rts_dly <= {rts_dly[LAG-2:0], i_rts};
    dtr_dly <= {dtr_dly[LAG-2:0], i_dtr};
  end
  assign o_pins = '{rlsd: i_carrier, ri: i_ring, dsr: dtr_dly[LAG-1], cts: rts_dly[LAG-1]};
  assign o_rx   = i_line;
endmodule : uml_data_set
`default_nettype wire

// File: verification/uml_modem_line_bench.sv
// uml_modem_line_bench: directed tests of modem control, line and modem status.
// assumes single-cycle host strobes and the far-end modem model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module uml_modem_line_bench;
  import uml_pkg::*;
  logic          clk, rst, io_wr, io_rd, tx_ser, port_irq, carrier, ring, line;
  logic          rx_pin, rx_ser, ser_out, rts, dtr, irq;
  logic [15:0]   addr;
  logic [7:0]    wdata, rdata;
  logic [19:0]   char_cycles;
  uml_tx_evt_t   tx_evt;
  uml_rx_evt_t   rx_evt;
  uml_irq_cond_t irq_cond;
  uml_modem_t    pins;
  int            err_total, compares, cycles;
  uml_modem_line DUT (.i_clk(clk), .i_sys_rst(rst), .i_io_addr(addr), .i_io_wr(io_wr), .i_io_rd(io_rd),
    .i_io_wdata(wdata), .o_io_rdata(rdata), .i_tx_ser(tx_ser), .i_tx_evt(tx_evt), .i_rx_evt(rx_evt),
    .i_char_cycles(char_cycles), .o_rx_ser(rx_ser), .i_port_irq(port_irq), .o_irq_cond(irq_cond),
    .o_irq(irq), .i_rx_pin(rx_pin), .i_modem_pins(pins), .o_ser_out(ser_out), .o_rts(rts), .o_dtr(dtr));
  uml_data_set #(.LAG(3)) u_far (.i_clk(clk), .i_rts(rts), .i_dtr(dtr), .i_carrier(carrier),
    .i_ring(ring), .i_line(line), .o_pins(pins), .o_rx(rx_pin));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  // every task starts one edge later, so no strobe is set twice in a step
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    tick(1);
    addr = a;
    wdata = d;
    io_wr = 1'b1;
    tick(1);
    io_wr = 1'b0;
  endtask : put
  task automatic rd(input logic [15:0] a);
    tick(1);
    addr = a;
    io_rd = 1'b1;
    tick(1);
    io_rd = 1'b0;
  endtask : rd
  task automatic get(input logic [15:0] a, input logic [7:0] e);
    rd(a);
    `CHK(rdata, e)
  endtask : get
  task automatic pulse(input uml_rx_evt_t r, input uml_tx_evt_t t);
    tick(1);
    rx_evt = r;
    tx_evt = t;
    tick(1);
    rx_evt = 4'h0;
    tx_evt = 3'h0;
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {io_wr, io_rd, tx_ser, port_irq, carrier, ring, err_total, compares, cycles} = '0;
    {addr, wdata, char_cycles, rx_evt, tx_evt} = '0;
    rst = 1'b1;
    line = 1'b1;
    tick(10);
    rst = 1'b0;
    tick(5);
    get(UML_ADDR_MCR, 8'h00);
    get(UML_ADDR_LSR, 8'h60);
    rd(UML_ADDR_MSR);
    get(UML_ADDR_MSR, 8'h00);
    put(16'h03ff, 8'hff);
    get(16'h03ff, 8'h00);
    get(UML_ADDR_MCR, 8'h00);
    $display("test reset done");
    put(UML_ADDR_MCR, 8'h07);
    tick(10);
    `CHK({rts, dtr}, 2'h3)
    get(UML_ADDR_MCR, 8'h07);
    get(UML_ADDR_MSR, 8'h33);
    get(UML_ADDR_MSR, 8'h30);
    carrier = 1'b1;
    ring = 1'b1;
    tick(6);
    get(UML_ADDR_MSR, 8'hfc);
    ring = 1'b0;
    tick(6);
    get(UML_ADDR_MSR, 8'hb0);
    carrier = 1'b0;
    tick(6);
    get(UML_ADDR_MSR, 8'h38);
    port_irq = 1'b1;
    tick(2);
    `CHK(irq, 1'b0)
    put(UML_ADDR_MCR, 8'h0b);
    tick(2);
    `CHK(irq, 1'b1)
    $display("test modem lines done");
    pulse(4'h8, 3'h0);
    pulse(4'h8, 3'h0);
    get(UML_ADDR_LSR, 8'h63);
    get(UML_ADDR_LSR, 8'h60);
    pulse(4'he, 3'h0);
    tick(1);
    `CHK(irq_cond, 4'he)
    get(UML_ADDR_LSR, 8'h6d);
    pulse(4'h8, 3'h0);
    put(UML_ADDR_LSR, 8'h00);
    get(UML_ADDR_LSR, 8'h60);
    pulse(4'h0, 3'h4);
    get(UML_ADDR_LSR, 8'h00);
    pulse(4'h0, 3'h2);
    get(UML_ADDR_LSR, 8'h20);
    pulse(4'h0, 3'h1);
    get(UML_ADDR_LSR, 8'h60);
    char_cycles = 20'h0_0014;
    tick(30);
    char_cycles = 20'h0_0000;
    get(UML_ADDR_LSR, 8'h70);
    $display("test line status done");
    tx_ser = 1'b1;
    tick(2);
    `CHK(ser_out, 1'b1)
    put(UML_ADDR_MCR, 8'h1f);
    tick(6);
    `CHK(ser_out, 1'b0)
    get(UML_ADDR_MSR, 8'hfc);
    carrier = 1'b1;
    put(UML_ADDR_MCR, 8'h13);
    tick(6);
    get(UML_ADDR_MSR, 8'h38);
    line = 1'b0;
    tx_ser = 1'b1;
    tick(3);
    `CHK(rx_ser, 1'b1)
    tx_ser = 1'b0;
    tick(3);
    `CHK(rx_ser, 1'b0)
    pulse(4'h8, 3'h0);
    get(UML_ADDR_LSR, 8'h61);
    put(UML_ADDR_LSR, 8'h3f);
    tick(1);
    `CHK(irq_cond, 4'he)
    get(UML_ADDR_LSR, 8'h7f);
    put(UML_ADDR_MSR, 8'h0f);
    tick(1);
    `CHK(irq_cond.modem_status, 1'b1)
    get(UML_ADDR_MSR, 8'h3f);
    get(UML_ADDR_MSR, 8'h30);
    put(UML_ADDR_MCR, 8'h00);
    carrier = 1'b0;
    line = 1'b1;
    tick(10);
    rd(UML_ADDR_MSR);
    put(UML_ADDR_MSR, 8'h0f);
    get(UML_ADDR_MSR, 8'h00);
    $display("test loopback done");
    print_verdict();
  end
endmodule : uml_modem_line_bench
`default_nettype wire
